// file: pkg/conv_seq_pkg.sv
package conv_seq_pkg;

  // command bytes (read / write)
  localparam logic [7:0] CMD_RD_GAIN   = 8'h27;
  localparam logic [7:0] CMD_WR_GAIN   = 8'h37;
  localparam logic [7:0] CMD_RD_IOFS   = 8'h28;
  localparam logic [7:0] CMD_WR_IOFS   = 8'h38;
  localparam logic [7:0] CMD_RD_QOFS   = 8'h29;
  localparam logic [7:0] CMD_WR_QOFS   = 8'h39;
  localparam logic [7:0] CMD_RD_CTL    = 8'h2A;
  localparam logic [7:0] CMD_WR_CTL    = 8'h3A;
  localparam logic [7:0] CMD_RD_DIV    = 8'h20;
  localparam logic [7:0] CMD_WR_DIV    = 8'h30;
  localparam logic [7:0] CMD_RD_STATUS = 8'h05;
  localparam logic [7:0] CMD_RD_DATA   = 8'h90;

  // values after reset
  localparam logic [2:0] GAIN_RESET = 3'h0;
  localparam logic [7:0] OFS_RESET  = 8'h00;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [3:0] DIV_RESET  = 4'h0;

  // external clock divider: codes 0..11 give 12..1, above give 1
  localparam logic [3:0] DIV_CODE_LAST = 4'hB;

  // settling length in measurement clock periods
  localparam logic [11:0] SETTLE_LEN_0 = 12'h640;
  localparam logic [11:0] SETTLE_LEN_1 = 12'h900;
  localparam logic [11:0] SETTLE_LEN_2 = 12'hA60;

  // accumulated i/q samples
  localparam logic [4:0] SAMPLES_0 = 5'h04;
  localparam logic [4:0] SAMPLES_1 = 5'h08;
  localparam logic [4:0] SAMPLES_2 = 5'h10;

  // converter clock period in measurement clock periods
  localparam logic [4:0] ADC_DIV_0 = 5'h10;
  localparam logic [4:0] ADC_DIV_1 = 5'h08;
  localparam logic [4:0] ADC_DIV_2 = 5'h04;

  // converter clock periods per i/q sample pair
  localparam logic [4:0] PAIR_PERIODS = 5'h16;

  // spi frame: command byte ends at bit 7, write data byte at bit 15
  localparam logic [5:0] CMD_LAST_BIT  = 6'h07;
  localparam logic [5:0] DATA_LAST_BIT = 6'h0F;
  localparam logic [5:0] BIT_CNT_MAX   = 6'h3F;

  localparam int SAMPLE_WIDTH = 10;
  localparam int RESULT_WIDTH = 14;

  typedef enum logic [1:0] {
    RUN_RESET  = 2'b00,
    RUN_SINGLE = 2'b01,
    RUN_CONT   = 2'b10,
    RUN_STOP   = 2'b11
  } run_cmd_e;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_SAMPLE = 2'b10
  } seq_state_e;

  typedef struct packed {
    logic [1:0] settling_length_sel;
    logic [1:0] sample_count_sel;
    logic [1:0] clk_sel;
    logic [1:0] run_cmd;
  } conversion_control_s;

endpackage

// file: logic/measure_tick_gen.sv
`timescale 1ns/1ps
module measure_tick_gen #(
  parameter int DIV_WIDTH = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [DIV_WIDTH-1:0] divider_code,
  output logic                      tick
);

  // the count table below is built for a 4-bit code only
  if (DIV_WIDTH != 4)
  begin : g_width_check
    $error("measure_tick_gen: divider code must be 4 bits");
  end

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       tick_reg;
  logic       tick_next;
  logic [3:0] last_cnt;

  always_comb
  begin
    // codes past the table all divide by one
    if (divider_code <= conv_seq_pkg::DIV_CODE_LAST)
      last_cnt = conv_seq_pkg::DIV_CODE_LAST - divider_code; // see RQ12
    else
      last_cnt = 4'h0;
    if (cnt_reg >= last_cnt)
    begin
      cnt_next  = 4'h0;
      tick_next = 1'b1;
    end
    else
    begin
      cnt_next  = cnt_reg + 4'h1;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule // measure_tick_gen

// file: logic/adc_conversion_sequencer.sv
// Summary of operation
// RQ1 - gain code 3-bit, write 37, read 27, reset 0
// RQ2 - gain code 000 highest, 111 lowest gain
// RQ3 - in-phase offset code: write 38, read 28
// RQ4 - quadrature offset code: write 39, read 29
// RQ5 - offset step lowers adc input 80 counts
// RQ6 - conversion control register: write 3A, read 2A
// RQ7 - bits 7:6 select settling length
// RQ8 - bits 5:4 select accumulated sample count
// RQ9 - results 12, 13 or 14 bits wide
// RQ10 - bits 3:2 select converter clock period
// RQ11 - bits 1:0 reset, single, continuous, stop
// RQ12 - measurement clock is divided clock, 1 to 12
// RQ13 - complete flag set at end, cleared by read/start
// RQ14 - settle then sample; continuous repeats until stopped
// RQ15 - each sample pair takes 22 converter periods
`timescale 1ns/1ps
module adc_conversion_sequencer (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  spi_sclk,
  input  wire logic                                  spi_cs_n,
  input  wire logic                                  spi_mosi,
  output logic                                       spi_miso,
  output logic                                       spi_miso_oe,
  input  wire logic [conv_seq_pkg::SAMPLE_WIDTH-1:0] adc_i_sample,
  input  wire logic [conv_seq_pkg::SAMPLE_WIDTH-1:0] adc_q_sample,
  output logic [2:0]                                 amplifier_gain_code,
  output logic [7:0]                                 inphase_offset_code,
  output logic [7:0]                                 quadrature_offset_code,
  output logic                                       sample_strobe,
  output logic                                       conversion_busy,
  output logic                                       conversion_done
);

  localparam int RW = conv_seq_pkg::RESULT_WIDTH;

  // pin synchronisers
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic       sclk_prev_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // idle pin levels: sclk low, cs_n high, so no false edge after reset
      pin_s1_reg    <= 3'h2;
      pin_s2_reg    <= 3'h2;
      sclk_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg    <= {spi_sclk, spi_cs_n, spi_mosi};
      pin_s2_reg    <= pin_s1_reg;
      sclk_prev_reg <= pin_s2_reg[2];
    end
  end

  logic sclk_rise;
  logic cs_active;
  logic mosi_bit;
  assign sclk_rise = pin_s2_reg[2] & ~sclk_prev_reg;
  assign cs_active = ~pin_s2_reg[1];
  assign mosi_bit  = pin_s2_reg[0];

  // spi framing
  logic [5:0]  bit_cnt_reg;
  logic [5:0]  bit_cnt_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_next;
  logic [7:0]  in_shift_reg;
  logic [7:0]  in_shift_next;
  logic [31:0] out_shift_reg;
  logic [31:0] out_shift_next;
  logic        wr_en;
  logic [7:0]  wr_data;
  logic        data_read;

  // configuration and sequencer state
  logic [2:0]                        gain_reg;
  logic [2:0]                        gain_next;
  logic [7:0]                        iofs_reg;
  logic [7:0]                        iofs_next;
  logic [7:0]                        qofs_reg;
  logic [7:0]                        qofs_next;
  conv_seq_pkg::conversion_control_s ctl_reg;
  conv_seq_pkg::conversion_control_s ctl_next;
  logic [3:0]                        div_reg;
  logic [3:0]                        div_next;
  conv_seq_pkg::seq_state_e          state_reg;
  conv_seq_pkg::seq_state_e          state_next;
  logic [11:0]                       settle_cnt_reg;
  logic [11:0]                       settle_cnt_next;
  logic [4:0]                        pre_cnt_reg;
  logic [4:0]                        pre_cnt_next;
  logic [4:0]                        phase_reg;
  logic [4:0]                        phase_next;
  logic [4:0]                        pair_cnt_reg;
  logic [4:0]                        pair_cnt_next;
  logic [RW-1:0]                     i_acc_reg;
  logic [RW-1:0]                     i_acc_next;
  logic [RW-1:0]                     q_acc_reg;
  logic [RW-1:0]                     q_acc_next;
  logic [RW-1:0]                     i_res_reg;
  logic [RW-1:0]                     i_res_next;
  logic [RW-1:0]                     q_res_reg;
  logic [RW-1:0]                     q_res_next;
  logic                              done_reg;
  logic                              done_next;
  logic                              strobe_reg;
  logic                              strobe_next;

  function automatic logic [31:0] read_value(input logic [7:0] cmd);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (cmd)
      conv_seq_pkg::CMD_RD_GAIN:   v[26:24] = gain_reg; // see RQ1
      conv_seq_pkg::CMD_RD_IOFS:   v[31:24] = iofs_reg; // see RQ3
      conv_seq_pkg::CMD_RD_QOFS:   v[31:24] = qofs_reg; // see RQ4
      conv_seq_pkg::CMD_RD_CTL:    v[31:24] = ctl_reg; // see RQ6
      conv_seq_pkg::CMD_RD_DIV:    v[27:24] = div_reg;
      conv_seq_pkg::CMD_RD_STATUS: v[24]    = done_reg; // see RQ13
      conv_seq_pkg::CMD_RD_DATA:   v = {{(16-RW){1'b0}}, i_res_reg, {(16-RW){1'b0}}, q_res_reg};
      default:                     v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb
  begin
    bit_cnt_next   = bit_cnt_reg;
    cmd_next       = cmd_reg;
    in_shift_next  = in_shift_reg;
    out_shift_next = out_shift_reg;
    wr_en          = 1'b0;
    wr_data        = {in_shift_reg[6:0], mosi_bit};
    data_read      = 1'b0;
    if (!cs_active)
      bit_cnt_next = 6'h00;
    else if (sclk_rise)
    begin
      in_shift_next = {in_shift_reg[6:0], mosi_bit};
      if (bit_cnt_reg != conv_seq_pkg::BIT_CNT_MAX)
        bit_cnt_next = bit_cnt_reg + 6'h01;
      if (bit_cnt_reg == conv_seq_pkg::CMD_LAST_BIT)
      begin
        // answer is loaded now and held until the host samples it
        cmd_next       = wr_data;
        out_shift_next = read_value(wr_data);
        data_read      = (wr_data == conv_seq_pkg::CMD_RD_DATA); // see RQ13
      end
      else if (bit_cnt_reg > conv_seq_pkg::CMD_LAST_BIT)
        out_shift_next = {out_shift_reg[30:0], 1'b0};
      if (bit_cnt_reg == conv_seq_pkg::DATA_LAST_BIT)
        wr_en = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_reg   <= 6'h00;
      cmd_reg       <= 8'h00;
      in_shift_reg  <= 8'h00;
      out_shift_reg <= 32'h0000_0000;
    end
    else
    begin
      bit_cnt_reg   <= bit_cnt_next;
      cmd_reg       <= cmd_next;
      in_shift_reg  <= in_shift_next;
      out_shift_reg <= out_shift_next;
    end
  end

  logic mtick;
  measure_tick_gen #(
    .DIV_WIDTH (4)
  ) u_tick (
    .clk          (clk),
    .rst_n        (rst_n),
    .divider_code (div_reg),
    .tick         (mtick)
  );

  logic [11:0] settle_len;
  logic [4:0]  sample_cnt;
  logic [4:0]  adc_div;
  logic        ctl_wr;
  logic        start;
  logic        halt;
  logic        adc_tick;
  logic        set_done;

  always_comb
  begin
    case (ctl_reg.settling_length_sel) // see RQ7
      2'b01:   settle_len = conv_seq_pkg::SETTLE_LEN_1;
      2'b10:   settle_len = conv_seq_pkg::SETTLE_LEN_2;
      default: settle_len = conv_seq_pkg::SETTLE_LEN_0;
    endcase
    case (ctl_reg.sample_count_sel) // see RQ8
      2'b01:   sample_cnt = conv_seq_pkg::SAMPLES_1;
      2'b10:   sample_cnt = conv_seq_pkg::SAMPLES_2;
      default: sample_cnt = conv_seq_pkg::SAMPLES_0;
    endcase
    case (ctl_reg.clk_sel) // see RQ10
      2'b01:   adc_div = conv_seq_pkg::ADC_DIV_1;
      2'b10:   adc_div = conv_seq_pkg::ADC_DIV_2;
      default: adc_div = conv_seq_pkg::ADC_DIV_0;
    endcase
  end

  always_comb
  begin
    ctl_wr    = wr_en && (cmd_reg == conv_seq_pkg::CMD_WR_CTL);
    start     = ctl_wr && (wr_data[1:0] == conv_seq_pkg::RUN_SINGLE || wr_data[1:0] == conv_seq_pkg::RUN_CONT);
    halt      = ctl_wr && !start; // see RQ11
    gain_next = (wr_en && cmd_reg == conv_seq_pkg::CMD_WR_GAIN) ? wr_data[2:0] : gain_reg; // see RQ1
    iofs_next = (wr_en && cmd_reg == conv_seq_pkg::CMD_WR_IOFS) ? wr_data : iofs_reg; // see RQ3
    qofs_next = (wr_en && cmd_reg == conv_seq_pkg::CMD_WR_QOFS) ? wr_data : qofs_reg; // see RQ4
    div_next  = (wr_en && cmd_reg == conv_seq_pkg::CMD_WR_DIV) ? wr_data[3:0] : div_reg; // see RQ12
    ctl_next  = ctl_wr ? wr_data : ctl_reg; // see RQ6
    adc_tick  = mtick && (pre_cnt_reg == adc_div - 5'h01);
    state_next      = state_reg;
    settle_cnt_next = settle_cnt_reg;
    pre_cnt_next    = pre_cnt_reg;
    phase_next      = phase_reg;
    pair_cnt_next   = pair_cnt_reg;
    i_acc_next      = i_acc_reg;
    q_acc_next      = q_acc_reg;
    i_res_next      = i_res_reg;
    q_res_next      = q_res_reg;
    set_done        = 1'b0;
    strobe_next     = 1'b0;
    if (mtick)
      pre_cnt_next = adc_tick ? 5'h00 : pre_cnt_reg + 5'h01;
    case (state_reg)
      conv_seq_pkg::SEQ_SETTLE:
      begin
        if (mtick)
        begin
          settle_cnt_next = settle_cnt_reg + 12'h001;
          if (settle_cnt_reg == settle_len - 12'h001) // see RQ14
          begin
            state_next    = conv_seq_pkg::SEQ_SAMPLE;
            pre_cnt_next  = 5'h00;
            phase_next    = 5'h00;
            pair_cnt_next = 5'h00;
            i_acc_next    = '0;
            q_acc_next    = '0;
          end
        end
      end
      conv_seq_pkg::SEQ_SAMPLE:
      begin
        if (adc_tick)
        begin
          phase_next = phase_reg + 5'h01;
          if (phase_reg == conv_seq_pkg::PAIR_PERIODS - 5'h01) // see RQ15
          begin
            // analog gain and offset act before these samples; 10-bit samples keep widths exact
            i_acc_next    = i_acc_reg + RW'(adc_i_sample); // see RQ9
            q_acc_next    = q_acc_reg + RW'(adc_q_sample); // see RQ9
            strobe_next   = 1'b1;
            phase_next    = 5'h00;
            pair_cnt_next = pair_cnt_reg + 5'h01;
            if (pair_cnt_reg == sample_cnt - 5'h01)
            begin
              i_res_next      = i_acc_next;
              q_res_next      = q_acc_next;
              set_done        = 1'b1; // see RQ13
              settle_cnt_next = 12'h000;
              state_next      = (ctl_reg.run_cmd == conv_seq_pkg::RUN_CONT) ?
                                conv_seq_pkg::SEQ_SETTLE : conv_seq_pkg::SEQ_IDLE; // see RQ14
            end
          end
        end
      end
      default:
        state_next = conv_seq_pkg::SEQ_IDLE;
    endcase
    if (start)
    begin
      state_next      = conv_seq_pkg::SEQ_SETTLE; // see RQ11
      settle_cnt_next = 12'h000;
      pre_cnt_next    = 5'h00;
    end
    else if (halt)
      state_next = conv_seq_pkg::SEQ_IDLE; // see RQ11
    if (ctl_wr && wr_data[1:0] == conv_seq_pkg::RUN_RESET)
    begin
      // dsp reset drops results as well as stopping
      i_acc_next = '0;
      q_acc_next = '0;
      i_res_next = '0;
      q_res_next = '0;
    end
    // a completion in the same cycle as a clear wins
    if (set_done)
      done_next = 1'b1;
    else if (start || data_read || (ctl_wr && wr_data[1:0] == conv_seq_pkg::RUN_RESET))
      done_next = 1'b0; // see RQ13
    else
      done_next = done_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain_reg       <= conv_seq_pkg::GAIN_RESET;
      iofs_reg       <= conv_seq_pkg::OFS_RESET;
      qofs_reg       <= conv_seq_pkg::OFS_RESET;
      ctl_reg        <= conv_seq_pkg::CTL_RESET;
      div_reg        <= conv_seq_pkg::DIV_RESET;
      state_reg      <= conv_seq_pkg::SEQ_IDLE;
      settle_cnt_reg <= 12'h000;
      pre_cnt_reg    <= 5'h00;
      phase_reg      <= 5'h00;
      pair_cnt_reg   <= 5'h00;
      i_acc_reg      <= '0;
      q_acc_reg      <= '0;
      i_res_reg      <= '0;
      q_res_reg      <= '0;
      done_reg       <= 1'b0;
      strobe_reg     <= 1'b0;
    end
    else
    begin
      gain_reg       <= gain_next;
      iofs_reg       <= iofs_next;
      qofs_reg       <= qofs_next;
      ctl_reg        <= ctl_next;
      div_reg        <= div_next;
      state_reg      <= state_next;
      settle_cnt_reg <= settle_cnt_next;
      pre_cnt_reg    <= pre_cnt_next;
      phase_reg      <= phase_next;
      pair_cnt_reg   <= pair_cnt_next;
      i_acc_reg      <= i_acc_next;
      q_acc_reg      <= q_acc_next;
      i_res_reg      <= i_res_next;
      q_res_reg      <= q_res_next;
      done_reg       <= done_next;
      strobe_reg     <= strobe_next;
    end
  end

  assign spi_miso               = out_shift_reg[31];
  assign spi_miso_oe            = cs_active;
  assign amplifier_gain_code    = gain_reg; // see RQ2
  assign inphase_offset_code    = iofs_reg; // see RQ5
  assign quadrature_offset_code = qofs_reg; // see RQ5
  assign sample_strobe          = strobe_reg;
  assign conversion_busy        = (state_reg != conv_seq_pkg::SEQ_IDLE);
  assign conversion_done        = done_reg;

endmodule // adc_conversion_sequencer

// file: test/conv_seq_monitor.sv
`timescale 1ns/1ps
module conv_seq_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       spi_cs_n,
  input wire logic       spi_miso_oe,
  input wire logic [2:0] amplifier_gain_code,
  input wire logic [7:0] inphase_offset_code,
  input wire logic [7:0] quadrature_offset_code,
  input wire logic       sample_strobe,
  input wire logic       conversion_busy,
  input wire logic       conversion_done
);
  // shortest cycle: 1600 settle ticks plus 4 pairs of 22 periods of 4 ticks
  localparam logic [15:0] MIN_RUN = 16'h07A0;
  logic [15:0] run_reg;
  logic [15:0] run_next;

  always_comb
  begin
    run_next = run_reg;
    if (!conversion_busy)
      run_next = 16'h0000;
    else if (run_reg != 16'hFFFF)
      run_next = run_reg + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_reg <= 16'h0000;
    else
      run_reg <= run_next;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  strobe_one_cycle_a: assert property (sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");
  strobe_in_run_a: assert property (sample_strobe |-> $past(conversion_busy))
    else $error("sample strobe outside a conversion");
  done_after_run_a: assert property ($rose(conversion_done) |-> $past(run_reg) >= MIN_RUN - 16'h0001)
    else $error("conversion done too early");
  done_with_pair_a: assert property ($rose(conversion_done) |-> sample_strobe || $past(sample_strobe))
    else $error("conversion done without a last pair");
  gain_hold_a: assert property (spi_cs_n [*4] |-> $stable(amplifier_gain_code))
    else $error("gain code changed outside a frame");
  inphase_hold_a: assert property (spi_cs_n [*4] |-> $stable(inphase_offset_code))
    else $error("in-phase offset changed outside a frame");
  quad_hold_a: assert property (spi_cs_n [*4] |-> $stable(quadrature_offset_code))
    else $error("quadrature offset changed outside a frame");
  start_by_host_a: assert property ($rose(conversion_busy) |-> !spi_cs_n || !$past(spi_cs_n, 3))
    else $error("conversion started without a frame");
  done_clear_a: assert property ($fell(conversion_done) |-> !spi_cs_n || !$past(spi_cs_n, 3))
    else $error("done cleared without a frame");
  busy_end_a: assert property ($fell(conversion_busy) |-> ##[0:1] (conversion_done || !spi_cs_n))
    else $error("conversion ended without done or stop");
  miso_oe_frame_a: assert property (!spi_cs_n [*4] |-> spi_miso_oe)
    else $error("data out not enabled inside a frame");
  miso_oe_idle_a: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("data out enabled outside a frame");
endmodule // conv_seq_monitor

bind adc_conversion_sequencer conv_seq_monitor u_conv_seq_monitor (
  .clk(clk),
  .rst_n(rst_n),
  .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe),
  .amplifier_gain_code(amplifier_gain_code),
  .inphase_offset_code(inphase_offset_code),
  .quadrature_offset_code(quadrature_offset_code),
  .sample_strobe(sample_strobe),
  .conversion_busy(conversion_busy),
  .conversion_done(conversion_done)
);

// file: test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // half sclk period in clk cycles; the device needs at least two
  localparam int HALF = 8;
  logic mosi_bit;
  logic idle_bit;

  // a deselected data line must not keep its last value
  assign spi_mosi = spi_cs_n ? idle_bit : mosi_bit;

  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    mosi_bit = 1'b0;
    idle_bit = 1'b0;
  end

  always @(posedge clk)
    idle_bit <= ~idle_bit;

  // command byte then nbits of data, msb first; a short nbits cuts the frame
  task automatic frame(input logic [7:0] cmd, input logic [31:0] wdata, input int nbits,
                       output logic [31:0] rdata);
    logic [39:0] sh;
    sh = {cmd, wdata << (32 - nbits)};
    rdata = 32'h0;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    mosi_bit <= sh[39];
    for (int b = 0; b < 8 + nbits; b++)
    begin
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b1;
      if (b >= 8)
        rdata = {rdata[30:0], spi_miso};
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b0;
      sh = sh << 1;
      mosi_bit <= sh[39];
    end
    repeat (HALF) @(posedge clk);
    spi_cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule // spi_host_model

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst_n;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic [9:0]  adc_i_sample;
  logic [9:0]  adc_q_sample;
  logic [2:0]  amplifier_gain_code;
  logic [7:0]  inphase_offset_code;
  logic [7:0]  quadrature_offset_code;
  logic        sample_strobe;
  logic        conversion_busy;
  logic        conversion_done;
  int          bad_count;
  int          n_tests;
  int          seed;
  int          busy_cnt;
  int          last_len;
  int          strobes;
  logic [31:0] r;
  logic [7:0]  v [3];

  adc_conversion_sequencer u_adc_conversion_sequencer (
    .clk(clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .adc_i_sample(adc_i_sample), .adc_q_sample(adc_q_sample),
    .amplifier_gain_code(amplifier_gain_code), .inphase_offset_code(inphase_offset_code),
    .quadrature_offset_code(quadrature_offset_code), .sample_strobe(sample_strobe),
    .conversion_busy(conversion_busy), .conversion_done(conversion_done)
  );
  spi_host_model u_spi_host_model (
    .clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  always #20 clk = ~clk;

  // length of the last busy stretch and pairs seen within it
  always @(posedge clk)
  begin
    busy_cnt <= conversion_busy ? busy_cnt + 1 : 0;
    if (!conversion_busy && busy_cnt != 0)
      last_len <= busy_cnt;
    if (conversion_busy && busy_cnt == 0)
      strobes <= 0;
    else if (sample_strobe)
      strobes <= strobes + 1;
  end

  task automatic close_out();
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic [31:0] x;
    u_spi_host_model.frame(cmd, {24'h0000_00, d}, 8, x);
  endtask

  task automatic rd(input logic [7:0] cmd, input int n, output logic [31:0] d);
    u_spi_host_model.frame(cmd, 32'h0, n, d);
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    while (conversion_done !== 1'b1 && k < 30000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 30000)
    begin
      bad_count++;
      close_out();
    end
  endtask

  function automatic int samples(input logic [7:0] c);
    return (c[5:4] == 2'b01) ? 8 : (c[5:4] == 2'b10) ? 16 : 4;
  endfunction

  function automatic int conv_len(input logic [7:0] c);
    int s;
    int a;
    s = (c[7:6] == 2'b01) ? 2304 : (c[7:6] == 2'b10) ? 2656 : 1600;
    a = (c[3:2] == 2'b01) ? 8 : (c[3:2] == 2'b10) ? 4 : 16;
    return s + samples(c) * 22 * a;
  endfunction

  task automatic single(input logic [7:0] c, input int tdiv, input logic [9:0] iv, input logic [9:0] qv);
    int n;
    int d;
    n = samples(c);
    adc_i_sample <= iv;
    adc_q_sample <= qv;
    wr(conv_seq_pkg::CMD_WR_CTL, c);
    rd(conv_seq_pkg::CMD_RD_CTL, 8, r);
    check("control", r, {24'h0000_00, c});
    wait_done();
    repeat (3) @(posedge clk);
    d = last_len - tdiv * conv_len(c);
    check("run length", (d < -tdiv - 3 || d > tdiv + 3) ? 32'(d) : 32'h0, 32'h0);
    check("pairs", 32'(strobes), 32'(n));
    check("busy", {31'h0, conversion_busy}, 32'h0);
    rd(conv_seq_pkg::CMD_RD_STATUS, 8, r);
    check("status set", r, 32'h1);
    rd(conv_seq_pkg::CMD_RD_DATA, 32, r);
    check("result", r, {2'b00, 14'(n * iv), 2'b00, 14'(n * qv)});
    check("done cleared", {31'h0, conversion_done}, 32'h0);
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    adc_i_sample = 10'h000;
    adc_q_sample = 10'h000;
    bad_count = 0;
    n_tests = 0;
    seed = 32'hAA5C_C96E;
    busy_cnt = 0;
    last_len = 0;
    strobes = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("miso enable idle", {31'h0, spi_miso_oe}, 32'h0);
    rd(conv_seq_pkg::CMD_RD_GAIN, 8, r);
    check("gain reset", r, 32'h0);
    rd(conv_seq_pkg::CMD_RD_DIV, 8, r);
    check("divider reset", r, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      v[0] = (k == 0) ? 8'h07 : 8'($random(seed));
      v[1] = (k == 0) ? 8'hFF : 8'($random(seed));
      v[2] = (k == 0) ? 8'h00 : 8'($random(seed));
      wr(conv_seq_pkg::CMD_WR_GAIN, v[0]);
      wr(conv_seq_pkg::CMD_WR_IOFS, v[1]);
      wr(conv_seq_pkg::CMD_WR_QOFS, v[2]);
      rd(conv_seq_pkg::CMD_RD_GAIN, 8, r);
      check("gain read", r, {29'h0, v[0][2:0]});
      check("gain pin", {29'h0, amplifier_gain_code}, {29'h0, v[0][2:0]});
      rd(conv_seq_pkg::CMD_RD_IOFS, 8, r);
      check("i offset read", r, {24'h0000_00, v[1]});
      check("i offset pin", {24'h0000_00, inphase_offset_code}, {24'h0000_00, v[1]});
      rd(conv_seq_pkg::CMD_RD_QOFS, 8, r);
      check("q offset read", r, {24'h0000_00, v[2]});
      check("q offset pin", {24'h0000_00, quadrature_offset_code}, {24'h0000_00, v[2]});
    end
    // a frame cut after four data bits must write nothing
    u_spi_host_model.frame(conv_seq_pkg::CMD_WR_IOFS, 32'h5, 4, r);
    check("cut frame", {24'h0000_00, inphase_offset_code}, {24'h0000_00, v[1]});
    // codes past the table must also divide by one
    wr(conv_seq_pkg::CMD_WR_DIV, 8'h0C);
    rd(conv_seq_pkg::CMD_RD_DIV, 8, r);
    check("divider read", r, 32'hC);
    for (int k = 0; k < 4; k++)
      single(8'(8'h01 + 8'h54 * k), 1, (k == 0) ? 10'h3FF : 10'($random(seed)), 10'($random(seed)));
    wr(conv_seq_pkg::CMD_WR_DIV, 8'h0A);
    single(8'h09, 2, 10'($random(seed)), 10'($random(seed)));
    wr(conv_seq_pkg::CMD_WR_CTL, 8'h0A);
    wait_done();
    repeat (5) @(posedge clk);
    check("continuous busy", {31'h0, conversion_busy}, 32'h1);
    wr(conv_seq_pkg::CMD_WR_CTL, 8'h0A);
    check("restart clears done", {31'h0, conversion_done}, 32'h0);
    wait_done();
    wr(conv_seq_pkg::CMD_WR_CTL, 8'h0B);
    check("stop busy", {31'h0, conversion_busy}, 32'h0);
    check("stop keeps done", {31'h0, conversion_done}, 32'h1);
    wr(conv_seq_pkg::CMD_WR_CTL, 8'h08);
    check("reset clears done", {31'h0, conversion_done}, 32'h0);
    rd(conv_seq_pkg::CMD_RD_DATA, 32, r);
    check("reset clears result", r, 32'h0);
    close_out();
  end
endmodule // tb
